/* rcm_pkg.sv */
// Package of constants and types for the return contact monitor.
`default_nettype none
package rcm_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_FLASH = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_SAMPLE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Status field positions.
  localparam int ST_ALARM = 0;
  localparam int ST_MONITORED = 1;
  localparam int ST_BASE_OK = 2;
  localparam int ST_RF_EN = 3;
  localparam int ST_PATH = 4;
  // Interrupt bit positions.
  localparam int IRQ_ALARM_SET = 0;
  localparam int IRQ_ALARM_CLR = 1;
  localparam int IRQ_BASE_UPD = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // Contact limits in ohms and the allowed rise in percent.
  localparam int LOW_OHMS = 5;
  localparam int HIGH_OHMS = 135;
  localparam int RISE_PCT = 40;
  localparam int CONT_OHMS = 20;
  // Timing: flash half period and gap between the two tones.
  localparam int CLK_MHZ = 100;
  localparam int FLASH_HALF_MS = 250;
  localparam int TONE_GAP_MS = 150;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
  localparam int TONE_GAP_CYC = TONE_GAP_MS * CLK_MHZ * 1000;
  localparam logic [31:0] FLASH_RST = 32'(FLASH_HALF_CYC);
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Contact monitor state.
  typedef enum logic [1:0] {
    MON_CLEAR = 2'b01,
    MON_ALARM = 2'b10
  } mon_state_t;
endpackage
`default_nettype wire

/* return_contact_monitor.sv */
// Return electrode contact monitor with AXI4-Lite registers.
// Function
// - Raise the contact alarm when the resistance is below 5 or above 135 ohms.
// - Capture the first contact resistance of a monitored electrode as baseline.
// - Raise the contact alarm when resistance rises more than 40% over baseline.
// - Replace the baseline whenever a lower resistance is measured; here only a lower reading of 5 ohms or more replaces it.
// - During a monitored alarm flash red, sound a tone and cut RF output.
// - Hold the alarm until the fault is gone, then show green and enable RF.
// - Monitoring runs when the electrode reported is of the monitored type.
// - A plain electrode is only checked for continuity and leaves the light dark.
// - A plain electrode above 20 ohms flashes red, sounds two tones, cuts RF.
// - After a continuity fault clears, turn red off and enable RF again.
// - Monopolar activation closes the return current path.
// - Bipolar activation opens the return circuit so no current disperses.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module return_contact_monitor
  import rcm_pkg::*;
#(
  parameter int RES_W    = 10,
  parameter int TONE_GAP = TONE_GAP_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [7:0]       s_axi_awaddr_i,
  input  wire logic             s_axi_awvalid_i,
  output logic                  s_axi_awready_o,
  input  wire logic [31:0]      s_axi_wdata_i,
  input  wire logic [3:0]       s_axi_wstrb_i,
  input  wire logic             s_axi_wvalid_i,
  output logic                  s_axi_wready_o,
  output logic [1:0]            s_axi_bresp_o,
  output logic                  s_axi_bvalid_o,
  input  wire logic             s_axi_bready_i,
  input  wire logic [7:0]       s_axi_araddr_i,
  input  wire logic             s_axi_arvalid_i,
  output logic                  s_axi_arready_o,
  output logic [31:0]           s_axi_rdata_o,
  output logic [1:0]            s_axi_rresp_o,
  output logic                  s_axi_rvalid_o,
  input  wire logic             s_axi_rready_i,
  input  wire logic             sample_valid_i,
  input  wire logic [RES_W-1:0] sample_ohms_i,
  input  wire logic             monitored_type_i,
  input  wire logic             mono_act_i,
  input  wire logic             bipolar_act_i,
  output logic                  led_red_o,
  output logic                  led_green_o,
  output logic                  tone_pulse_o,
  output logic                  rf_enable_o,
  output logic                  return_path_closed_o,
  output logic                  irq_o
);

  localparam int PW = RES_W + 8;

  // All state of the block in one record.
  typedef struct packed {
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [31:0]      flash_half;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    mon_state_t       mon;
    logic             monitored;
    logic             base_ok;
    logic [RES_W-1:0] base;
    logic [RES_W-1:0] sample;
    logic [31:0]      flash_cnt;
    logic             flash_on;
    logic [1:0]       tones_left;
    logic [31:0]      gap_cnt;
    logic             tone;
    logic             led_red;
    logic             led_green;
    logic             rf_en;
    logic             path_closed;
  } state_t;

  state_t q;
  state_t next_q;

  // Mapped offsets answer OKAY; anything else gets SLVERR.
  function automatic logic addr_ok(input logic [7:0] a);
    unique case (a)
      OFS_FLASH, OFS_STATUS, OFS_BASE, OFS_SAMPLE,
      OFS_IRQ_STAT, OFS_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // Merge a write into a 32-bit word under byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  logic [31:0]      status_word;
  logic [PW-1:0]    rise_lhs;
  logic [PW-1:0]    rise_rhs;
  logic             fault_mon;
  logic             fault_cont;
  logic             fault;
  logic             type_now;
  logic [IRQ_W-1:0] events;

  // Channel readiness follows the captured flags directly.
  assign s_axi_awready_o = !q.aw_got && !q.bvalid;
  assign s_axi_wready_o = !q.w_got && !q.bvalid;
  assign s_axi_arready_o = !q.rvalid;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign led_red_o = q.led_red;
  assign led_green_o = q.led_green;
  assign tone_pulse_o = q.tone;
  assign rf_enable_o = q.rf_en;
  assign return_path_closed_o = q.path_closed;
  assign irq_o = |(q.irq_stat & q.irq_mask);

  // Fault evaluation of the incoming sample; the rise test avoids a divider
  // by cross-multiplying, which is exact for integer ohms.
  always_comb begin
    type_now = monitored_type_i;
    rise_lhs = PW'(sample_ohms_i) * PW'(100);
    rise_rhs = PW'(q.base) * PW'(100 + RISE_PCT);
    fault_mon = (sample_ohms_i < RES_W'(LOW_OHMS))
             || (sample_ohms_i > RES_W'(HIGH_OHMS))
             || (q.base_ok && type_now == q.monitored
                 && rise_lhs > rise_rhs);
    fault_cont = sample_ohms_i > RES_W'(CONT_OHMS);
    fault = type_now ? fault_mon : fault_cont;
  end

  // Status word as seen by software.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_ALARM] = q.mon == MON_ALARM;
    status_word[ST_MONITORED] = q.monitored;
    status_word[ST_BASE_OK] = q.base_ok;
    status_word[ST_RF_EN] = q.rf_en;
    status_word[ST_PATH] = q.path_closed;
  end

  // Next-state logic for bus, monitor, indicator, tone and return path.
  always_comb begin
    next_q = q;
    events = '0;
    next_q.tone = 1'b0;

    // Write address and data may arrive in either order.
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_q.aw_got = 1'b1;
      next_q.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_q.w_got = 1'b1;
      next_q.w_data = s_axi_wdata_i;
      next_q.w_strb = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      next_q.bvalid = 1'b0;
    end

    // Read: data is registered on the same edge that takes the address.
    if (q.rvalid && s_axi_rready_i) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr_i)
        OFS_FLASH: next_q.rdata = q.flash_half;
        OFS_STATUS: next_q.rdata = status_word;
        OFS_BASE: next_q.rdata = 32'(q.base);
        OFS_SAMPLE: next_q.rdata = 32'(q.sample);
        OFS_IRQ_STAT: next_q.rdata = 32'(q.irq_stat);
        OFS_IRQ_MASK: next_q.rdata = 32'(q.irq_mask);
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    // Sample evaluation; a change of electrode type forgets the baseline.
    if (sample_valid_i) begin
      next_q.sample = sample_ohms_i;
      next_q.monitored = type_now;
      if (type_now != q.monitored) begin
        next_q.base_ok = 1'b0;
      end
      if (type_now && !fault) begin
        if (!next_q.base_ok) begin
          next_q.base = sample_ohms_i;
          next_q.base_ok = 1'b1;
          events[IRQ_BASE_UPD] = 1'b1;
        end else if (sample_ohms_i < q.base) begin
          next_q.base = sample_ohms_i;
          events[IRQ_BASE_UPD] = 1'b1;
        end
      end
      unique case (q.mon)
        MON_CLEAR: begin
          if (fault) begin
            next_q.mon = MON_ALARM;
            next_q.tones_left = type_now ? 2'd1 : 2'd2;
            next_q.gap_cnt = 32'h0000_0000;
            events[IRQ_ALARM_SET] = 1'b1;
          end
        end
        MON_ALARM: begin
          if (!fault) begin
            next_q.mon = MON_CLEAR;
            events[IRQ_ALARM_CLR] = 1'b1;
          end
        end
      endcase
    end

    // Tone pulses, spaced by a gap so two tones are heard as two.
    if (q.tones_left != 2'd0) begin
      if (q.gap_cnt == 32'h0000_0000) begin
        next_q.tone = 1'b1;
        next_q.tones_left = q.tones_left - 2'd1;
        next_q.gap_cnt = 32'(TONE_GAP);
      end else begin
        next_q.gap_cnt = q.gap_cnt - 32'h0000_0001;
      end
    end

    // Flash divider runs only in alarm and starts in the lit phase so the
    // red light shows on the first cycle of the alarm. Counting begins one
    // cycle after entry, so even a period of 0 or 1 lights red at once.
    if (q.mon == MON_ALARM) begin
      if (q.flash_cnt + 32'h0000_0001 >= q.flash_half) begin
        next_q.flash_cnt = 32'h0000_0000;
        next_q.flash_on = !q.flash_on;
      end else begin
        next_q.flash_cnt = q.flash_cnt + 32'h0000_0001;
      end
    end else begin
      next_q.flash_cnt = 32'h0000_0000;
      next_q.flash_on = 1'b1;
    end

    // Indicators and RF gate follow the monitor state.
    next_q.led_red = (next_q.mon == MON_ALARM) && next_q.flash_on;
    next_q.led_green = (next_q.mon == MON_CLEAR) && next_q.monitored;
    next_q.rf_en = next_q.mon == MON_CLEAR;

    // Bipolar takes priority so the return pad can never share its current.
    next_q.path_closed = mono_act_i && !bipolar_act_i;

    // Register write once both halves are in; hardware events win the clear.
    if (q.aw_got && q.w_got) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = addr_ok(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (q.aw_addr)
        OFS_FLASH: next_q.flash_half = merge(q.flash_half, q.w_data, q.w_strb);
        OFS_IRQ_STAT: begin
          if (q.w_strb[0]) begin
            next_q.irq_stat = q.irq_stat & ~q.w_data[IRQ_W-1:0];
          end
        end
        OFS_IRQ_MASK: begin
          if (q.w_strb[0]) begin
            next_q.irq_mask = q.w_data[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    next_q.irq_stat = next_q.irq_stat | events;
  end

  // State register; RF stays off after reset until a good sample arrives.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.flash_half <= FLASH_RST;
      q.irq_mask <= IRQ_MASK_RST;
      q.mon <= MON_ALARM;
      q.flash_on <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

/* return_contact_monitor_chk.sv */
// Port-level checks on the return contact monitor.
`default_nettype none
module return_contact_monitor_chk
  import rcm_pkg::*;
#(
  parameter int RES_W = 10
) (
  input wire logic             clk_i,
  input wire logic             reset_n_i,
  input wire logic             sample_valid_i,
  input wire logic [RES_W-1:0] sample_ohms_i,
  input wire logic             monitored_type_i,
  input wire logic             mono_act_i,
  input wire logic             bipolar_act_i,
  input wire logic             led_red_o,
  input wire logic             led_green_o,
  input wire logic             tone_pulse_o,
  input wire logic             rf_enable_o,
  input wire logic             return_path_closed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Each sample decides RF and the lamps on the very next edge.
  a_range_alarm:
    assert property (sample_valid_i && monitored_type_i && (sample_ohms_i < LOW_OHMS
      || sample_ohms_i > HIGH_OHMS) |=> !rf_enable_o && !led_green_o)
    else $error("range fault did not cut RF");
  a_cont_fault:
    assert property (sample_valid_i && !monitored_type_i && sample_ohms_i > CONT_OHMS
      |=> !rf_enable_o && !led_green_o) else $error("continuity fault did not cut RF");
  a_cont_good:
    assert property (sample_valid_i && !monitored_type_i && sample_ohms_i <= CONT_OHMS
      |-> ##1 rf_enable_o && !led_red_o && !led_green_o)
    else $error("plain electrode lamps or RF wrong");
  // Entering alarm lights red at once and asks for a tone one cycle later.
  a_alarm_red:
    assert property ($fell(rf_enable_o) |-> led_red_o && !led_green_o)
    else $error("alarm entry without red lamp");
  a_alarm_tone:
    assert property ($fell(rf_enable_o) |=> tone_pulse_o) else $error("alarm without tone");
  a_tone_pulse:
    assert property ($rose(tone_pulse_o) |=> !tone_pulse_o) else $error("tone not one cycle");
  // The return path follows the activation one cycle late.
  a_path_close:
    assert property (mono_act_i && !bipolar_act_i |=> return_path_closed_o)
    else $error("monopolar did not close path");
  a_path_open:
    assert property (bipolar_act_i |=> !return_path_closed_o)
    else $error("bipolar did not open path");
endmodule
bind return_contact_monitor return_contact_monitor_chk #(.RES_W(RES_W)) chk_u (
  .clk_i, .reset_n_i, .sample_valid_i, .sample_ohms_i, .monitored_type_i, .mono_act_i,
  .bipolar_act_i, .led_red_o, .led_green_o, .tone_pulse_o, .rf_enable_o,
  .return_path_closed_o);
`default_nettype wire

/* return_sense_model.sv */
// Behavioural model of the return electrode resistance sensing circuit.
`default_nettype none
module return_sense_model #(
  parameter int RES_W = 10
) (
  input  wire logic             clk_i,
  output var logic             valid_o,
  output var logic [RES_W-1:0] ohms_o,
  output var logic             mon_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle until the first sample is sent.
  initial begin
    valid_o = 1'b0;
    ohms_o = '0;
    mon_o = 1'b0;
  end
  // One strobed sample; the type flag stays with the electrode.
  task automatic send(input logic [RES_W-1:0] ohms, input logic mon);
    @(posedge clk_i);
    valid_o <= 1'b1;
    ohms_o <= ohms;
    mon_o <= mon;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Stale converter data is shown inverted so no one relies on it.
    ohms_o <= ~ohms;
  endtask
endmodule
`default_nettype wire

/* return_contact_monitor_tb.sv */
// Self-checking bench for the return contact monitor.
`default_nettype none
module return_contact_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcm_pkg::*;
  localparam int RES_W = 10;
  logic             clk_i = 1'b0, reset_n_i = 1'b0, mono_act_i = 1'b0, bipolar_act_i = 1'b0;
  logic             s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic             s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0]       s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0]      s_axi_wdata_i = 32'h0, s_axi_rdata_o, rv;
  logic [3:0]       s_axi_wstrb_i = 4'hF;
  logic [1:0]       s_axi_bresp_o, s_axi_rresp_o, rr;
  logic             s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic             s_axi_rvalid_o, sample_valid_i, monitored_type_i, led_red_o, led_green_o;
  logic             tone_pulse_o, rf_enable_o, return_path_closed_o, irq_o, red_q;
  logic [RES_W-1:0] sample_ohms_i;
  int               num_errors = 0, checks = 0, tones = 0, flips = 0;
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  return_contact_monitor #(.RES_W(RES_W), .TONE_GAP(8)) dut_u (.clk_i, .reset_n_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .sample_valid_i, .sample_ohms_i, .monitored_type_i,
    .mono_act_i, .bipolar_act_i, .led_red_o, .led_green_o, .tone_pulse_o, .rf_enable_o,
    .return_path_closed_o, .irq_o);
  return_sense_model #(.RES_W(RES_W)) sens_u (.clk_i, .valid_o(sample_valid_i),
    .ohms_o(sample_ohms_i), .mon_o(monitored_type_i));
  // Tones and lamp changes are counted mid-cycle, where outputs are settled.
  always @(negedge clk_i) begin
    tones <= tones + int'(tone_pulse_o === 1'b1);
    flips <= flips + int'(led_red_o !== red_q);
    red_q <= led_red_o;
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Write: both halves offered together, each dropped once taken; ready is judged mid-cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_axi_awvalid_i && s_axi_awready_o;
      tw = s_axi_wvalid_i && s_axi_wready_o;
      tb = s_axi_bvalid_o;
      rr = s_axi_bresp_o;
      @(posedge clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
    end while (!tb);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_axi_arvalid_i && s_axi_arready_o;
      tr = s_axi_rvalid_o;
      rv = s_axi_rdata_o;
      rr = s_axi_rresp_o;
      @(posedge clk_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
    end while (!tr);
    s_axi_rready_i <= 1'b0;
  endtask
  // Send one sample, then check RF and both lamps; red is lit exactly when RF is cut.
  task automatic smp(input logic [RES_W-1:0] o, input logic t, input logic rf, input logic g);
    sens_u.send(o, t);
    @(negedge clk_i);
    cmp("rf", 32'(rf), 32'(rf_enable_o));
    cmp("green", 32'(g), 32'(led_green_o));
    cmp("red", 32'(!rf), 32'(led_red_o));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hang would show long before this span, which is about fifty times the expected run.
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    cmp("rf", 32'h0, 32'(rf_enable_o));
    rd(OFS_FLASH);
    cmp("flash", FLASH_RST, rv);
    rd(8'h18);
    cmp("resp", 32'(RESP_SLVERR), 32'(rr));
    wr(OFS_FLASH, 32'h4);
    cmp("bresp", 32'(RESP_OKAY), 32'(rr));
    rd(OFS_FLASH);
    cmp("flash", 32'h4, rv);
    wr(8'h18, 32'h1);
    cmp("bresp", 32'(RESP_SLVERR), 32'(rr));
    $display("test registers done");
    smp(10'h032, 1'b1, 1'b1, 1'b1);
    rd(OFS_BASE);
    cmp("base", 32'h32, rv);
    rd(OFS_STATUS);
    cmp("status", 32'((1 << ST_MONITORED) | (1 << ST_BASE_OK) | (1 << ST_RF_EN)), rv);
    rd(OFS_SAMPLE);
    cmp("sample", 32'h32, rv);
    smp(10'h046, 1'b1, 1'b1, 1'b1);
    smp(10'h047, 1'b1, 1'b0, 1'b0);
    smp(10'h028, 1'b1, 1'b1, 1'b1);
    rd(OFS_BASE);
    cmp("base", 32'h28, rv);
    smp(10'h00A, 1'b0, 1'b1, 1'b0);
    smp(10'h088, 1'b1, 1'b0, 1'b0);
    smp(10'h087, 1'b1, 1'b1, 1'b1);
    smp(10'h004, 1'b1, 1'b0, 1'b0);
    smp(10'h005, 1'b1, 1'b1, 1'b1);
    $display("test monitored done");
    smp(10'h015, 1'b0, 1'b0, 1'b0);
    @(posedge clk_i);
    tones <= 0;
    flips <= 0;
    repeat (21) @(negedge clk_i);
    cmp("tones", 32'h2, 32'(tones));
    cmp("flips", 32'h5, 32'(flips));
    smp(10'h014, 1'b0, 1'b1, 1'b0);
    $display("test continuity done");
    rd(OFS_IRQ_STAT);
    cmp("irq_stat", 32'h7, rv);
    cmp("irq", 32'h0, 32'(irq_o));
    wr(OFS_IRQ_MASK, 32'h1);
    @(negedge clk_i);
    cmp("irq", 32'h1, 32'(irq_o));
    wr(OFS_IRQ_STAT, 32'h7);
    @(negedge clk_i);
    cmp("irq", 32'h0, 32'(irq_o));
    $display("test interrupt done");
    @(posedge clk_i);
    mono_act_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    cmp("path", 32'h1, 32'(return_path_closed_o));
    @(posedge clk_i);
    bipolar_act_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    cmp("path", 32'h0, 32'(return_path_closed_o));
    $display("test path done");
    complete_run();
  end
endmodule
`default_nettype wire
